// [ima_framer_consts.vh]
// Shared constants of the ATM inverse multiplexing framer.
`ifndef IMA_FRAMER_CONSTS_VH
`define IMA_FRAMER_CONSTS_VH
`define N_LINKS 4
`define N_GROUPS 2
`define HDR_W 40
`define WORD_W 32
`define CELL_W 72
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define CTRL_HDR 40'h0000000B64
`define STUFF_PERIOD 12'h801
`define SI_NONE 3'h7
`define SI_NEXT 3'h1
`define SI_EVENT 3'h0
`define KIND_DATA 2'h0
`define KIND_FILL 2'h1
`define KIND_CTRL 2'h2
`define KIND_STUFF 2'h3
`define FLEN_SEL_128 2'h0
`define FLEN_SEL_32 2'h1
`define FLEN_SEL_64 2'h2
`define FLEN_SEL_256 2'h3
`define CELL_ID_BIT 31
`define LINK_ID_LSB 24
`define FSN_LSB 16
`define OFFSET_LSB 8
`define SI_LSB 0
`endif

// [ima_cell_fifo.v]
// Cell FIFO with a registered head word.
`timescale 1ns/1ps
module ima_cell_fifo #(
  parameter W = 72,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire load = (cnt_q != {(AW+1){1'b0}}) && (!out_valid || out_ready);
  assign in_ready = (cnt_q != D[AW:0]);
  always @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      if (load) begin
        out_data <= mem[rp_q];
        rp_q <= rp_q + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// [ima_rx_link.v]
// Receive frame aligner and cell screener of one link.
`timescale 1ns/1ps
`include "ima_framer_consts.vh"
module ima_rx_link (
  input wire clk,
  input wire rst,
  input wire en,
  input wire [8:0] flen,
  input wire in_valid,
  output wire in_ready,
  input wire [`HDR_W-1:0] in_hdr,
  input wire [`WORD_W-1:0] in_word,
  output reg out_valid,
  input wire out_ready,
  output reg [`HDR_W-1:0] out_hdr,
  output reg [`WORD_W-1:0] out_word,
  output wire aligned
);
  localparam HUNT = 1'b0;
  localparam SYNC = 1'b1;
  reg st_q;
  reg stuff_q;
  reg [8:0] slot_q;
  wire is_oh = (in_hdr == `CTRL_HDR);
  wire is_ctrl = is_oh && in_word[`CELL_ID_BIT];
  wire is_fill = is_oh && !in_word[`CELL_ID_BIT];
  wire si_ev = (in_word[`SI_LSB+2:`SI_LSB] == `SI_EVENT);
  wire take = in_valid && in_ready;
  assign in_ready = !out_valid || out_ready;
  assign aligned = (st_q == SYNC);
  always @(posedge clk) begin
    if (rst) begin
      st_q <= HUNT;
      stuff_q <= 1'b0;
      slot_q <= 9'h000;
      out_valid <= 1'b0;
      out_hdr <= {`HDR_W{1'b0}};
      out_word <= {`WORD_W{1'b0}};
    end else begin
      if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (!en) begin
        st_q <= HUNT;
        stuff_q <= 1'b0;
      end else if (take) begin
        case (st_q)
          HUNT: begin
            if (is_ctrl) begin
              st_q <= SYNC;
              stuff_q <= si_ev;
              slot_q <= 9'h001;
            end
          end
          SYNC: begin
            if (stuff_q) begin
              // The announced second control cell is dropped and takes no slot.
              stuff_q <= 1'b0;
              if (!(is_ctrl && si_ev)) begin
                st_q <= HUNT;
              end
            end else if (slot_q == 9'h000) begin
              if (is_ctrl) begin
                stuff_q <= si_ev;
                slot_q <= 9'h001;
              end else begin
                st_q <= HUNT;
              end
            end else if (is_ctrl) begin
              st_q <= HUNT;
            end else begin
              slot_q <= (slot_q == flen - 9'h001) ? 9'h000 : slot_q + 9'h001;
              if (!is_fill) begin
                out_valid <= 1'b1;
                out_hdr <= in_hdr;
                out_word <= in_word;
              end
            end
          end
          default: st_q <= HUNT;
        endcase
      end
    end
  end
endmodule

// [ima_frame_cell_framer.v]
// Top of the framer: transmit framing per link, receive merge of all links onto one port.
`timescale 1ns/1ps
`include "ima_framer_consts.vh"
module ima_frame_cell_framer (
  input wire CORE_CLK,
  input wire SRST,
  input wire ATM_TX_VALID,
  output wire ATM_TX_READY,
  input wire ATM_TX_GROUP,
  input wire [`HDR_W-1:0] ATM_TX_HDR,
  input wire [`WORD_W-1:0] ATM_TX_WORD,
  output reg ATM_RX_VALID,
  input wire ATM_RX_READY,
  output reg ATM_RX_GROUP,
  output reg [`HDR_W-1:0] ATM_RX_HDR,
  output reg [`WORD_W-1:0] ATM_RX_WORD,
  input wire [`N_LINKS-1:0] LINK_GROUP,
  input wire [`N_LINKS-1:0] LINK_TX_EN,
  input wire [`N_LINKS-1:0] LINK_RX_EN,
  input wire [3:0] REF_LINK,
  input wire [3:0] FRAME_SEL,
  output wire [`N_LINKS-1:0] LINK_TX_VALID,
  input wire [`N_LINKS-1:0] LINK_TX_READY,
  output wire [2*`N_LINKS-1:0] LINK_TX_KIND,
  output wire [`HDR_W*`N_LINKS-1:0] LINK_TX_HDR,
  output wire [`WORD_W*`N_LINKS-1:0] LINK_TX_WORD,
  input wire [`N_LINKS-1:0] LINK_RX_VALID,
  output wire [`N_LINKS-1:0] LINK_RX_READY,
  input wire [`HDR_W*`N_LINKS-1:0] LINK_RX_HDR,
  input wire [`WORD_W*`N_LINKS-1:0] LINK_RX_WORD,
  output wire [`N_LINKS-1:0] LINK_RX_ALIGNED
);
  localparam TX_IDLE = 2'h0;
  localparam TX_CTRL = 2'h1;
  localparam TX_STUFF = 2'h2;
  localparam TX_DATA = 2'h3;

  // Selector code 0 falls through to the default of 128 so that a cleared setting is the default length.
  function [8:0] frame_len;
    input [1:0] sel;
    begin
      case (sel)
        `FLEN_SEL_32: frame_len = 9'h020;
        `FLEN_SEL_64: frame_len = 9'h040;
        `FLEN_SEL_256: frame_len = 9'h100;
        default: frame_len = 9'h080;
      endcase
    end
  endfunction

  // Group 1 keeps its reference link number in the upper two bits.
  function [1:0] ref_of;
    input grp;
    input [3:0] refs;
    begin
      ref_of = grp ? refs[3:2] : refs[1:0];
    end
  endfunction

  // Each group takes its frame length from its own pair of selector bits.
  function [8:0] group_len;
    input grp;
    input [3:0] sels;
    begin
      group_len = frame_len(grp ? sels[3:2] : sels[1:0]);
    end
  endfunction

  // Control, stuff and filler words share one layout; the offset stays 0 as frames open on the control cell.
  function [`WORD_W-1:0] ovh_word;
    input cell_id;
    input [1:0] link;
    input [7:0] fsn;
    input [2:0] si;
    begin
      ovh_word = {`WORD_W{1'b0}};
      ovh_word[`CELL_ID_BIT] = cell_id;
      ovh_word[`LINK_ID_LSB +: 2] = link;
      ovh_word[`FSN_LSB +: 8] = fsn;
      ovh_word[`OFFSET_LSB +: 8] = 8'h00;
      ovh_word[`SI_LSB +: 3] = si;
    end
  endfunction

  wire [`N_GROUPS-1:0] f_valid;
  wire [`CELL_W*`N_GROUPS-1:0] f_data;
  wire [`N_GROUPS-1:0] f_in_ready;
  wire [`N_LINKS-1:0] want;
  wire [`N_LINKS-1:0] frame_start;
  reg [`N_LINKS-1:0] grant;
  reg [`N_GROUPS-1:0] pop;
  integer k;
  integer r;

  // Cells for a group enter under one address and are shared by all its links.
  assign ATM_TX_READY = f_in_ready[ATM_TX_GROUP];

  genvar g;
  generate
    for (g = 0; g < `N_GROUPS; g = g + 1) begin : grp
      // Each group owns its buffer, so a stalled group never blocks another.
      ima_cell_fifo #(
        .W(`CELL_W),
        .D(`FIFO_DEPTH),
        .AW(`FIFO_AW)
      ) u_fifo (
        .clk(CORE_CLK),
        .rst(SRST),
        .in_valid(ATM_TX_VALID && (ATM_TX_GROUP == g)),
        .in_ready(f_in_ready[g]),
        .in_data({ATM_TX_HDR, ATM_TX_WORD}),
        .out_valid(f_valid[g]),
        .out_ready(pop[g]),
        .out_data(f_data[g*`CELL_W +: `CELL_W])
      );
    end
  endgenerate

  // The lowest numbered link that wants a cell wins its group's head word.
  always @* begin
    grant = {`N_LINKS{1'b0}};
    pop = {`N_GROUPS{1'b0}};
    for (k = 0; k < `N_LINKS; k = k + 1) begin
      if (want[k] && !pop[LINK_GROUP[k]]) begin
        grant[k] = 1'b1;
        pop[LINK_GROUP[k]] = 1'b1;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < `N_LINKS; i = i + 1) begin : tx
      localparam [1:0] ID = i;
      reg [1:0] st_q;
      reg [8:0] slot_q;
      reg [7:0] fsn_q;
      reg [11:0] cnt_q;
      reg pend_q;
      reg ann_q;
      reg ov_q;
      reg [1:0] kind_q;
      reg [`HDR_W-1:0] hdr_q;
      reg [`WORD_W-1:0] word_q;

      wire [1:0] refl = ref_of(LINK_GROUP[i], REF_LINK);
      wire is_ref = (refl == ID);
      wire [8:0] m = group_len(LINK_GROUP[i], FRAME_SEL);
      wire [`CELL_W-1:0] head = LINK_GROUP[i] ? f_data[2*`CELL_W-1:`CELL_W] : f_data[`CELL_W-1:0];
      wire fv = LINK_GROUP[i] ? f_valid[1] : f_valid[0];
      // A cell stays in the output register until the link takes it, so no slot is ever lost.
      wire adv = !ov_q || LINK_TX_READY[i];
      wire emit = adv && LINK_TX_EN[i] && (st_q != TX_IDLE);
      // The code reads 001 one control cell ahead of the stuff pair and 000 on both cells of it.
      wire [2:0] si = (pend_q && ann_q) ? `SI_EVENT : (pend_q ? `SI_NEXT : `SI_NONE);
      wire [`WORD_W-1:0] oh_word = ovh_word(1'b1, ID, fsn_q, si);
      wire [`WORD_W-1:0] fill_word = ovh_word(1'b0, ID, fsn_q, `SI_NONE);

      // A link asks for the head word only when its cell really goes out this cycle.
      assign want[i] = adv && LINK_TX_EN[i] && (st_q == TX_DATA) && fv;
      assign frame_start[i] = adv && LINK_TX_EN[i] && (st_q == TX_CTRL);
      assign LINK_TX_VALID[i] = ov_q;
      assign LINK_TX_KIND[2*i +: 2] = kind_q;
      assign LINK_TX_HDR[`HDR_W*i +: `HDR_W] = hdr_q;
      assign LINK_TX_WORD[`WORD_W*i +: `WORD_W] = word_q;

      // This is the transmit link state machine; the receive one lives in the aligner.
      always @(posedge CORE_CLK) begin
        if (SRST) begin
          st_q <= TX_IDLE;
          slot_q <= 9'h000;
          fsn_q <= 8'h00;
          cnt_q <= 12'h000;
          pend_q <= 1'b0;
          ann_q <= 1'b0;
          ov_q <= 1'b0;
          kind_q <= `KIND_DATA;
          hdr_q <= {`HDR_W{1'b0}};
          word_q <= {`WORD_W{1'b0}};
        end else if (adv) begin
          ov_q <= 1'b0;
          if (!LINK_TX_EN[i]) begin
            st_q <= TX_IDLE;
          end else begin
            case (st_q)
              TX_IDLE: begin
                // A joining link starts its frames on the reference link's frame boundary.
                if (is_ref || frame_start[refl]) begin
                  st_q <= TX_CTRL;
                  slot_q <= 9'h000;
                end
              end
              TX_CTRL: begin
                ov_q <= 1'b1;
                kind_q <= `KIND_CTRL;
                hdr_q <= `CTRL_HDR;
                word_q <= oh_word;
                fsn_q <= fsn_q + 8'h01;
                slot_q <= 9'h001;
                // A pending stuff is announced in one control cell and carried out after the next.
                if (pend_q && ann_q) begin
                  st_q <= TX_STUFF;
                  pend_q <= 1'b0;
                  ann_q <= 1'b0;
                end else begin
                  st_q <= TX_DATA;
                  if (pend_q) begin
                    ann_q <= 1'b1;
                  end
                end
              end
              TX_STUFF: begin
                // The stuff cell repeats the control word just sent, event code included.
                ov_q <= 1'b1;
                kind_q <= `KIND_STUFF;
                st_q <= TX_DATA;
              end
              TX_DATA: begin
                ov_q <= 1'b1;
                if (grant[i]) begin
                  kind_q <= `KIND_DATA;
                  hdr_q <= head[`CELL_W-1:`WORD_W];
                  word_q <= head[`WORD_W-1:0];
                end else begin
                  // Filler, never an idle cell, keeps the slot.
                  kind_q <= `KIND_FILL;
                  hdr_q <= `CTRL_HDR;
                  word_q <= fill_word;
                end
                if (slot_q == m - 9'h001) begin
                  st_q <= TX_CTRL;
                  slot_q <= 9'h000;
                end else begin
                  slot_q <= slot_q + 9'h001;
                end
              end
              default: st_q <= TX_IDLE;
            endcase
          end
          // Counted after the state logic so a new stuff request is never lost to a clear.
          if (emit) begin
            if (cnt_q == `STUFF_PERIOD - 12'h001) begin
              cnt_q <= 12'h000;
              pend_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 12'h001;
            end
          end
        end
      end
    end
  endgenerate

  // Receive side: one aligner per link, merged onto the single ATM-layer port.
  wire [`N_LINKS-1:0] rv;
  wire [`N_LINKS-1:0] rready;
  wire [`N_LINKS-1:0] elig;
  wire [`HDR_W*`N_LINKS-1:0] rhdr;
  wire [`WORD_W*`N_LINKS-1:0] rword;
  reg [1:0] rr_q;
  reg [1:0] sel;
  reg [1:0] idx;
  reg found;
  wire rx_load = !ATM_RX_VALID || ATM_RX_READY;

  generate
    for (i = 0; i < `N_LINKS; i = i + 1) begin : rx
      localparam [1:0] ID = i;
      // Every link has its own cell port into the engine.
      ima_rx_link u_link (
        .clk(CORE_CLK),
        .rst(SRST),
        .en(LINK_RX_EN[i]),
        .flen(group_len(LINK_GROUP[i], FRAME_SEL)),
        .in_valid(LINK_RX_VALID[i]),
        .in_ready(LINK_RX_READY[i]),
        .in_hdr(LINK_RX_HDR[`HDR_W*i +: `HDR_W]),
        .in_word(LINK_RX_WORD[`WORD_W*i +: `WORD_W]),
        .out_valid(rv[i]),
        .out_ready(rready[i]),
        .out_hdr(rhdr[`HDR_W*i +: `HDR_W]),
        .out_word(rword[`WORD_W*i +: `WORD_W]),
        .aligned(LINK_RX_ALIGNED[i])
      );
      // Payload of a group waits until its reference link holds frame alignment.
      assign elig[i] = rv[i] && LINK_RX_ALIGNED[ref_of(LINK_GROUP[i], REF_LINK)];
      assign rready[i] = rx_load && found && (sel == ID);
    end
  endgenerate

  // Round robin over links keeps one busy link from starving the others.
  always @* begin
    found = 1'b0;
    sel = 2'h0;
    idx = 2'h0;
    for (r = 0; r < `N_LINKS; r = r + 1) begin
      idx = rr_q + r[1:0];
      if (!found && elig[idx]) begin
        found = 1'b1;
        sel = idx;
      end
    end
  end

  // Cells are not reordered across links, so differential delay can reach the ATM layer as reordering.
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      rr_q <= 2'h0;
      ATM_RX_VALID <= 1'b0;
      ATM_RX_GROUP <= 1'b0;
      ATM_RX_HDR <= {`HDR_W{1'b0}};
      ATM_RX_WORD <= {`WORD_W{1'b0}};
    end else if (rx_load) begin
      ATM_RX_VALID <= found;
      if (found) begin
        // The group number is the single address the ATM layer sees.
        ATM_RX_GROUP <= LINK_GROUP[sel];
        ATM_RX_HDR <= rhdr[`HDR_W*sel +: `HDR_W];
        ATM_RX_WORD <= rword[`WORD_W*sel +: `WORD_W];
        rr_q <= sel + 2'h1;
      end
    end
  end
endmodule

// [ima_framer_monitor.sv]
// Checker of the framer's link-0 transmit stream and its ATM-layer receive port.
`timescale 1ns/1ps
`include "ima_framer_consts.vh"
module ima_framer_monitor (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic ATM_RX_VALID,
  input wire logic ATM_RX_READY,
  input wire logic [`HDR_W-1:0] ATM_RX_HDR,
  input wire logic [`WORD_W-1:0] ATM_RX_WORD,
  input wire logic [`N_LINKS-1:0] LINK_GROUP,
  input wire logic [3:0] FRAME_SEL,
  input wire logic [`N_LINKS-1:0] LINK_TX_VALID,
  input wire logic [`N_LINKS-1:0] LINK_TX_READY,
  input wire logic [2*`N_LINKS-1:0] LINK_TX_KIND,
  input wire logic [`HDR_W*`N_LINKS-1:0] LINK_TX_HDR,
  input wire logic [`WORD_W*`N_LINKS-1:0] LINK_TX_WORD,
  input wire logic [`N_LINKS-1:0] LINK_RX_ALIGNED
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  wire v0 = LINK_TX_VALID[0];
  wire tk0 = v0 && LINK_TX_READY[0];
  wire [1:0] k0 = LINK_TX_KIND[1:0];
  wire [39:0] h0 = LINK_TX_HDR[39:0];
  wire [31:0] w0 = LINK_TX_WORD[31:0];
  wire [1:0] sel0 = LINK_GROUP[0] ? FRAME_SEL[3:2] : FRAME_SEL[1:0];
  wire [8:0] m0 = sel0 == 2'h1 ? 9'h020 : sel0 == 2'h2 ? 9'h040 : sel0 == 2'h3 ? 9'h100 : 9'h080;
  logic [1:0] lk_q;
  logic [2:0] lsi_q;
  logic [2:0] csi_q;
  logic [7:0] fsn_q;
  logic [8:0] cnt_q;
  logic seen_q;
  // Stuff cells do not occupy a payload slot, so they are left out of the slot count.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      seen_q <= 1'b0;
      cnt_q <= 9'h000;
      lk_q <= 2'h0;
      lsi_q <= 3'h0;
      csi_q <= 3'h0;
      fsn_q <= 8'h00;
    end else if (tk0) begin
      lk_q <= k0;
      lsi_q <= w0[2:0];
      if (k0 == `KIND_CTRL) begin
        seen_q <= 1'b1;
        csi_q <= w0[2:0];
        fsn_q <= w0[23:16];
        cnt_q <= 9'h000;
      end else if (k0 != `KIND_STUFF) begin
        cnt_q <= cnt_q + 9'h001;
      end
    end
  end
  property p_ctrl_hdr; tk0 && k0 == `KIND_CTRL |-> h0 == `CTRL_HDR && w0[31]; endproperty
  a_ctrl_hdr: assert property (p_ctrl_hdr) else $error("control cell header wrong");
  property p_fill; tk0 && k0 == `KIND_FILL |-> h0 == `CTRL_HDR && !w0[31] && w0[2:0] == `SI_NONE; endproperty
  a_fill: assert property (p_fill) else $error("filler cell format wrong");
  property p_stuff_pos; tk0 && k0 == `KIND_STUFF |-> lk_q == `KIND_CTRL && lsi_q == `SI_EVENT && w0[2:0] == `SI_EVENT;
  endproperty
  a_stuff_pos: assert property (p_stuff_pos) else $error("stuff cell misplaced");
  property p_si_seq; tk0 && k0 == `KIND_CTRL && seen_q |-> (csi_q == `SI_NEXT) == (w0[2:0] == `SI_EVENT); endproperty
  a_si_seq: assert property (p_si_seq) else $error("stuff indication sequence wrong");
  property p_fsn; tk0 && k0 == `KIND_CTRL && seen_q |-> w0[23:16] == fsn_q + 8'h01; endproperty
  a_fsn: assert property (p_fsn) else $error("frame sequence number step wrong");
  property p_frame; tk0 && k0 == `KIND_CTRL && seen_q |-> cnt_q == m0 - 9'h001; endproperty
  a_frame: assert property (p_frame) else $error("payload slots per frame wrong");
  property p_no_idle; v0 |-> h0 != 40'h0000000152; endproperty
  a_no_idle: assert property (p_no_idle) else $error("idle cell sent on link");
  property p_tx_hold; v0 && !LINK_TX_READY[0] |=> v0 && $stable(h0) && $stable(w0) && $stable(k0); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("link cell changed before taken");
  property p_rx_hold; ATM_RX_VALID && !ATM_RX_READY |=> ATM_RX_VALID && $stable(ATM_RX_HDR) && $stable(ATM_RX_WORD);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("received cell changed before taken");
  property p_rx_nofill; ATM_RX_VALID |-> ATM_RX_HDR != `CTRL_HDR; endproperty
  a_rx_nofill: assert property (p_rx_nofill) else $error("overhead cell forwarded");
  property p_rx_align; ATM_RX_VALID |-> LINK_RX_ALIGNED != 4'h0; endproperty
  a_rx_align: assert property (p_rx_align) else $error("cell forwarded without alignment");
  c_stuff: cover property (tk0 && k0 == `KIND_STUFF);
  c_wrap: cover property (tk0 && k0 == `KIND_CTRL && seen_q && w0[23:16] == 8'h00);
  c_rx: cover property (ATM_RX_VALID && ATM_RX_READY);
endmodule

// [ima_link_partner.sv]
// Link path model: loops each transmitted cell back to the same link's receive side.
`timescale 1ns/1ps
`include "ima_framer_consts.vh"
module ima_link_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`N_LINKS-1:0] stall,
  input wire logic [`N_LINKS-1:0] tx_valid,
  output logic [`N_LINKS-1:0] tx_ready,
  input wire logic [`HDR_W*`N_LINKS-1:0] tx_hdr,
  input wire logic [`WORD_W*`N_LINKS-1:0] tx_word,
  output logic [`N_LINKS-1:0] rx_valid,
  input wire logic [`N_LINKS-1:0] rx_ready,
  output logic [`HDR_W*`N_LINKS-1:0] rx_hdr,
  output logic [`WORD_W*`N_LINKS-1:0] rx_word
);
  // One cell slot per link halves throughput but keeps the return path free of combinational loops.
  always_comb tx_ready = ~stall & ~rx_valid;
  always_ff @(posedge clk) begin
    for (int i = 0; i < `N_LINKS; i++) begin
      if (rst) begin
        rx_valid[i] <= 1'b0;
        rx_hdr[i*`HDR_W +: `HDR_W] <= 40'h0;
        rx_word[i*`WORD_W +: `WORD_W] <= 32'h0;
      end else if (tx_valid[i] && tx_ready[i]) begin
        rx_valid[i] <= 1'b1;
        rx_hdr[i*`HDR_W +: `HDR_W] <= tx_hdr[i*`HDR_W +: `HDR_W];
        rx_word[i*`WORD_W +: `WORD_W] <= tx_word[i*`WORD_W +: `WORD_W];
      end else if (rx_valid[i] && rx_ready[i]) begin
        rx_valid[i] <= 1'b0;
        rx_hdr[i*`HDR_W +: `HDR_W] <= ~rx_hdr[i*`HDR_W +: `HDR_W];
        rx_word[i*`WORD_W +: `WORD_W] <= ~rx_word[i*`WORD_W +: `WORD_W];
      end
    end
  end
endmodule

// [tb_top.sv]
// Testbench: framer with a loopback link model and ATM-layer traffic.
`timescale 1ns/1ps
`include "ima_framer_consts.vh"
module tb_top;
  logic CORE_CLK = 1'h0, SRST = 1'h1, ATM_TX_VALID = 1'h0, ATM_TX_GROUP = 1'h0, ATM_RX_READY = 1'h1;
  logic ATM_TX_READY, ATM_RX_VALID, ATM_RX_GROUP;
  logic [`HDR_W-1:0] ATM_TX_HDR = 40'h0, ATM_RX_HDR;
  logic [`WORD_W-1:0] ATM_TX_WORD = 32'h0, ATM_RX_WORD;
  logic [3:0] LINK_GROUP = 4'h0, LINK_TX_EN = 4'h0, LINK_RX_EN = 4'h0, REF_LINK = 4'h0, FRAME_SEL = 4'h0;
  logic [3:0] stall = 4'h0, LINK_TX_VALID, LINK_TX_READY, LINK_RX_VALID, LINK_RX_READY, LINK_RX_ALIGNED;
  logic [7:0] LINK_TX_KIND;
  logic [159:0] LINK_TX_HDR, LINK_RX_HDR;
  logic [127:0] LINK_TX_WORD, LINK_RX_WORD;
  int num_errors = 0, checks_done = 0, cyc = 0, n0, last_at, gap, ctl_n, si1_at, stf_at, wrap;
  logic [71:0] rq0[$], rq1[$], eq0[$], eq1[$];
  always #20 CORE_CLK = ~CORE_CLK;
  ima_frame_cell_framer u_ima_frame_cell_framer (.CORE_CLK, .SRST, .ATM_TX_VALID, .ATM_TX_READY, .ATM_TX_GROUP,
    .ATM_TX_HDR, .ATM_TX_WORD, .ATM_RX_VALID, .ATM_RX_READY, .ATM_RX_GROUP, .ATM_RX_HDR, .ATM_RX_WORD,
    .LINK_GROUP, .LINK_TX_EN, .LINK_RX_EN, .REF_LINK, .FRAME_SEL, .LINK_TX_VALID, .LINK_TX_READY, .LINK_TX_KIND,
    .LINK_TX_HDR, .LINK_TX_WORD, .LINK_RX_VALID, .LINK_RX_READY, .LINK_RX_HDR, .LINK_RX_WORD, .LINK_RX_ALIGNED);
  ima_link_partner u_ima_link_partner (.clk(CORE_CLK), .rst(SRST), .stall(stall), .tx_valid(LINK_TX_VALID),
    .tx_ready(LINK_TX_READY), .tx_hdr(LINK_TX_HDR), .tx_word(LINK_TX_WORD), .rx_valid(LINK_RX_VALID),
    .rx_ready(LINK_RX_READY), .rx_hdr(LINK_RX_HDR), .rx_word(LINK_RX_WORD));
  always @(posedge CORE_CLK) begin
    cyc++;
    if (LINK_TX_VALID[0] && LINK_TX_READY[0]) begin
      n0++;
      if (LINK_TX_KIND[1:0] == `KIND_STUFF && stf_at == 0) stf_at = n0;
      if (LINK_TX_KIND[1:0] == `KIND_CTRL) begin
        gap = n0 - last_at;
        last_at = n0;
        ctl_n++;
        if (LINK_TX_WORD[2:0] == `SI_NEXT && si1_at == 0) si1_at = n0;
        if (LINK_TX_WORD[23:16] == 8'h00 && ctl_n > 1) wrap = 1;
      end
    end
    if (ATM_RX_VALID && ATM_RX_READY) begin
      if (ATM_RX_GROUP) rq1.push_back({ATM_RX_HDR, ATM_RX_WORD});
      else rq0.push_back({ATM_RX_HDR, ATM_RX_WORD});
    end
    #1 ATM_RX_READY = cyc % 3 != 0;
    // A run past the ceiling counts as a mismatch and ends through the closing report.
    if (cyc > 45000) begin
      num_errors++;
      complete_run;
    end
  end
  task chk(input string nm, input logic [71:0] got, input logic [71:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task start(input logic [3:0] sel, input logic [3:0] grp, input logic [3:0] refl, input logic [3:0] en);
    @(posedge CORE_CLK);
    #1;
    SRST = 1'h1;
    FRAME_SEL = sel;
    LINK_GROUP = grp;
    REF_LINK = refl;
    {n0, last_at, ctl_n, si1_at, stf_at, wrap} = '0;
    repeat (3) @(posedge CORE_CLK);
    #1;
    SRST = 1'h0;
    LINK_TX_EN = en;
    LINK_RX_EN = en;
  endtask
  task put(input logic g, input logic [7:0] i, output logic took);
    ATM_TX_VALID = 1'h1;
    ATM_TX_GROUP = g;
    ATM_TX_HDR = {24'h0ABC00, i, 8'h55};
    ATM_TX_WORD = {16'hC0DE, 7'h00, g, i};
    took = 1'h0;
    for (int k = 0; k < 40 && !took; k++) begin
      @(negedge CORE_CLK);
      took = ATM_TX_READY;
      @(posedge CORE_CLK);
      #1;
    end
    if (took && g) eq1.push_back({ATM_TX_HDR, ATM_TX_WORD});
    if (took && !g) eq0.push_back({ATM_TX_HDR, ATM_TX_WORD});
  endtask
  task t_frames;
    int m[4] = '{128, 32, 64, 256};
    for (int c = 0; c < 4; c++) begin
      start(4'(c), 4'h0, 4'h0, 4'h1);
      for (int i = 0; i < 3000 && ctl_n < 3; i++) @(posedge CORE_CLK);
      #1;
      chk("frame length", gap, m[c]);
    end
  endtask
  task t_data;
    logic took;
    int n;
    start(4'h1, 4'hC, 4'h8, 4'h5);
    for (int i = 0; i < 2000 && LINK_RX_ALIGNED != 4'h5; i++) @(posedge CORE_CLK);
    #1;
    chk("aligned", LINK_RX_ALIGNED, 4'h5);
    stall = 4'h1;
    n = 0;
    took = 1'h1;
    while (took && n < 40) begin
      put(1'h0, 8'(n), took);
      if (took) n++;
    end
    chk("accepted until full", n, `FIFO_DEPTH + 1);
    stall = 4'h0;
    put(1'h0, 8'(n), took);
    for (int j = 0; j < 5; j++) put(1'h1, 8'(8'h80 + j), took);
    ATM_TX_VALID = 1'h0;
    for (int i = 0; i < 3000 && (rq0.size() < eq0.size() || rq1.size() < eq1.size()); i++) @(posedge CORE_CLK);
    #1;
    chk("group0 count", rq0.size(), eq0.size());
    chk("group1 count", rq1.size(), eq1.size());
    foreach (eq0[i]) chk("group0 cell", rq0[i], eq0[i]);
    foreach (eq1[i]) chk("group1 cell", rq1[i], eq1[i]);
  endtask
  task t_stuff;
    start(4'h1, 4'h0, 4'h0, 4'h1);
    for (int i = 0; i < 8000 && stf_at == 0; i++) @(posedge CORE_CLK);
    #1;
    chk("stuff notice", si1_at > 2049 && si1_at <= 2082, 1'h1);
    chk("stuff place", stf_at, si1_at + 33);
    chk("rx aligned", LINK_RX_ALIGNED[0], 1'h1);
    for (int i = 0; i < 20000 && !wrap; i++) @(posedge CORE_CLK);
    #1;
    chk("sequence wrap", wrap, 1);
  endtask
  initial begin
    t_frames;
    t_data;
    t_stuff;
    complete_run;
  end
endmodule
bind ima_frame_cell_framer ima_framer_monitor u_ima_framer_monitor (.CORE_CLK, .SRST, .ATM_RX_VALID, .ATM_RX_READY,
  .ATM_RX_HDR, .ATM_RX_WORD, .LINK_GROUP, .FRAME_SEL, .LINK_TX_VALID, .LINK_TX_READY, .LINK_TX_KIND, .LINK_TX_HDR,
  .LINK_TX_WORD, .LINK_RX_ALIGNED);
